/* File: dcrc_cfg.svh */
// dcrc_cfg.svh: register indices, reset values, field positions and codes
// assumes: included by bare name from the package and the register block
`ifndef DCRC_CFG_SVH
`define DCRC_CFG_SVH
// ==========================================================================
// register indices (byte address is four times the index)
`define DCRC_IDX_HIBERNATE 16'hF400
`define DCRC_IDX_RUN 16'hF402
`define DCRC_IDX_ABORT 16'hF403
`define DCRC_IDX_ENTRY 16'hF404
`define DCRC_IDX_STATE 16'hF405
`define DCRC_IDX_CLEAR 16'hF421
`define DCRC_IDX_PMASK 16'hF422
`define DCRC_IDX_FLAG 16'hF427
`define DCRC_IDX_IRQST 16'hF430
`define DCRC_IDX_IRQMSK 16'hF431
`define DCRC_ADDR_W 18
// ==========================================================================
// reset values and fields
`define DCRC_RST_ZERO 16'h0000
`define DCRC_RST_PMASK 16'h0003
`define DCRC_PMASK_W 12
`define DCRC_TRIG_BIT 0
// ==========================================================================
// core state codes as read back
`define DCRC_CODE_STOP 3'b000
`define DCRC_CODE_RUN 3'b001
`define DCRC_CODE_PAUSE 3'b010
`define DCRC_CODE_SLEEP 3'b011
`define DCRC_CODE_STALL 3'b100
// ==========================================================================
// interrupt status bits
`define DCRC_IRQ_W 3
`define DCRC_IRQ_START 0
`define DCRC_IRQ_HALT 1
`define DCRC_IRQ_FAULT 2
// ==========================================================================
// bus responses
`define DCRC_RESP_OKAY 2'b00
`define DCRC_RESP_SLVERR 2'b10
`endif

/* File: dcrc_pkg.sv */
// dcrc_pkg.sv: types shared by the run control block
// assumes: dcrc_cfg.svh on the include path
`include "dcrc_cfg.svh"
package dcrc_pkg;
    // ======================================================================
    // core condition, gray coded along stop-run-stall-pause-sleep
    typedef enum logic [2:0] {
        DCRC_ST_STOP = 3'b000,
        DCRC_ST_RUN = 3'b001,
        DCRC_ST_STALL = 3'b011,
        DCRC_ST_PAUSE = 3'b010,
        DCRC_ST_SLEEP = 3'b110
    } dcrc_state_t;
    typedef logic [15:0] dcrc_word_t;
endpackage : dcrc_pkg

/* File: dcrc_core_run_control.sv */
// dcrc_core_run_control.sv: run control, state readback and fault clear
// assumes: AXI4-Lite master on core_clk, core status inputs synchronous
//
// Summary of operation
// - run bit rising edge enables core and launches the program counter
// - run bit falling edge does nothing
// - abort bit rising edge halts core at once from any state
// - abort bit falling edge does nothing
// - after abort the state code reads not running
// - program counter starts at the 16-bit entry register value
// - state reads not running after reset, running while executing
// - state reads paused after a pause instruction until resumed
// - state reads sleep after a sleep instruction until next sample with hibernate clear
// - state reads stalled while serving requests, then resumes at once
// - state field is live and ignores software writes
// - clear bit rising edge clears fault flag and resets fault manager
// - parity report mask bits set stop those memories reporting faults, resets to 3
// - hibernate masks interrupts, sleeps after current block completes
// - fault flag records any unmasked functional block error
`include "dcrc_cfg.svh"
module dcrc_core_run_control #(
    parameter int PMASK_W = `DCRC_PMASK_W
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [`DCRC_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [`DCRC_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic coreStallReq,
    input wire logic corePauseInstr,
    input wire logic coreResume,
    input wire logic coreSleepInstr,
    input wire logic frameStart,
    input wire logic blockDone,
    input wire logic [PMASK_W-1:0] parityErr,
    input wire logic otherFault,
    output logic coreEnable,
    output logic pcLoad,
    output logic [15:0] pcStartAddr,
    output logic coreHaltNow,
    output logic coreIrqMask,
    output logic faultMgrReset,
    output logic [PMASK_W-1:0] parityReportMask,
    output logic faultFlag,
    output logic [2:0] coreStateCode,
    output logic irq
);
    // ======================================================================
    // bus holding registers
    logic awHeld;
    logic [15:0] awIdx;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic [15:0] rdVal;
    logic rdHit;
    logic wrHit;
    logic wrBit;

    // ======================================================================
    // software state
    logic hibernate;
    logic runTrig;
    logic abortTrig;
    logic [15:0] entry;
    logic clearTrig;
    logic [`DCRC_IRQ_W-1:0] irqStatus;
    logic [`DCRC_IRQ_W-1:0] irqMask;
    logic runRise;
    logic abortRise;
    logic clearRise;
    logic faultSet;
    logic [`DCRC_IRQ_W-1:0] irqEvent;
    dcrc_pkg::dcrc_state_t state;
    dcrc_pkg::dcrc_state_t next_state;

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    function automatic logic isMapped(input logic [15:0] idx);
        logic hit;
        hit = 1'b0;
        case (idx)
            `DCRC_IDX_HIBERNATE,
            `DCRC_IDX_RUN,
            `DCRC_IDX_ABORT,
            `DCRC_IDX_ENTRY,
            `DCRC_IDX_STATE,
            `DCRC_IDX_CLEAR,
            `DCRC_IDX_PMASK,
            `DCRC_IDX_FLAG,
            `DCRC_IDX_IRQST,
            `DCRC_IDX_IRQMSK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : isMapped

    // ======================================================================
    // write channels, taken in either order
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign doWrite = awHeld && wHeld && !bvalid;
    assign wrHit = isMapped(awIdx);
    assign wrBit = wStrb[0] ? wData[`DCRC_TRIG_BIT] : 1'b0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld <= 1'b0;
            awIdx <= 16'h0000;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            awIdx <= awaddr[`DCRC_ADDR_W-1:2];
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wData <= wdata;
            wStrb <= wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= `DCRC_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? `DCRC_RESP_OKAY : `DCRC_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ======================================================================
    // trigger bits: only the stored bit going from zero to one acts
    assign runRise = doWrite && awIdx == `DCRC_IDX_RUN && wStrb[0]
        && wrBit && !runTrig;
    assign abortRise = doWrite && awIdx == `DCRC_IDX_ABORT && wStrb[0]
        && wrBit && !abortTrig;
    assign clearRise = doWrite && awIdx == `DCRC_IDX_CLEAR && wStrb[0]
        && wrBit && !clearTrig;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            runTrig <= 1'b0;
            abortTrig <= 1'b0;
            clearTrig <= 1'b0;
            hibernate <= 1'b0;
        end else if (doWrite && wStrb[0]) begin
            // upper bits are not stored
            case (awIdx)
                `DCRC_IDX_RUN: runTrig <= wrBit;
                `DCRC_IDX_ABORT: abortTrig <= wrBit;
                `DCRC_IDX_CLEAR: clearTrig <= wrBit;
                `DCRC_IDX_HIBERNATE: hibernate <= wrBit;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            entry <= `DCRC_RST_ZERO;
        end else if (doWrite && awIdx == `DCRC_IDX_ENTRY) begin
            entry <= merge16(entry, wData, wStrb);
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            parityReportMask <= PMASK_W'(`DCRC_RST_PMASK);
        end else if (doWrite && awIdx == `DCRC_IDX_PMASK) begin
            parityReportMask <= PMASK_W'(merge16(16'(parityReportMask),
                wData, wStrb));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqMask <= '0;
        end else if (doWrite && awIdx == `DCRC_IDX_IRQMSK && wStrb[0]) begin
            irqMask <= wData[`DCRC_IRQ_W-1:0];
        end
    end

    // ======================================================================
    // core condition tracking
    always_comb begin
        next_state = state;
        case (state)
            dcrc_pkg::DCRC_ST_STOP: begin
                if (runRise) begin
                    next_state = dcrc_pkg::DCRC_ST_RUN;
                end
            end
            dcrc_pkg::DCRC_ST_RUN: begin
                if (coreStallReq) begin
                    next_state = dcrc_pkg::DCRC_ST_STALL;
                end else if (corePauseInstr) begin
                    next_state = dcrc_pkg::DCRC_ST_PAUSE;
                end else if (coreSleepInstr) begin
                    next_state = dcrc_pkg::DCRC_ST_SLEEP;
                end else if (hibernate && blockDone) begin
                    next_state = dcrc_pkg::DCRC_ST_SLEEP;
                end
            end
            dcrc_pkg::DCRC_ST_STALL: begin
                if (!coreStallReq) begin
                    next_state = dcrc_pkg::DCRC_ST_RUN;
                end
            end
            dcrc_pkg::DCRC_ST_PAUSE: begin
                if (coreResume) begin
                    next_state = dcrc_pkg::DCRC_ST_RUN;
                end
            end
            dcrc_pkg::DCRC_ST_SLEEP: begin
                if (frameStart && !hibernate) begin
                    next_state = dcrc_pkg::DCRC_ST_RUN;
                end
            end
            default: next_state = dcrc_pkg::DCRC_ST_STOP;
        endcase
        if (runRise) begin
            next_state = dcrc_pkg::DCRC_ST_RUN;
        end
        if (abortRise) begin
            next_state = dcrc_pkg::DCRC_ST_STOP;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= dcrc_pkg::DCRC_ST_STOP;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        case (state)
            dcrc_pkg::DCRC_ST_RUN: coreStateCode = `DCRC_CODE_RUN;
            dcrc_pkg::DCRC_ST_STALL: coreStateCode = `DCRC_CODE_STALL;
            dcrc_pkg::DCRC_ST_PAUSE: coreStateCode = `DCRC_CODE_PAUSE;
            dcrc_pkg::DCRC_ST_SLEEP: coreStateCode = `DCRC_CODE_SLEEP;
            default: coreStateCode = `DCRC_CODE_STOP;
        endcase
    end

    assign coreEnable = state != dcrc_pkg::DCRC_ST_STOP;
    assign coreIrqMask = hibernate;

    // launch and halt strobes to the core, one cycle each
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pcLoad <= 1'b0;
            pcStartAddr <= 16'h0000;
            coreHaltNow <= 1'b0;
        end else begin
            pcLoad <= runRise && !abortRise;
            coreHaltNow <= abortRise;
            if (runRise) begin
                pcStartAddr <= entry;
            end
        end
    end

    // ======================================================================
    // fault manager flag: a new fault beats a clear in the same cycle
    assign faultSet = |(parityErr & ~parityReportMask) || otherFault;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            faultFlag <= 1'b0;
            faultMgrReset <= 1'b0;
        end else begin
            faultMgrReset <= clearRise;
            if (faultSet) begin
                faultFlag <= 1'b1;
            end else if (clearRise) begin
                faultFlag <= 1'b0;
            end
        end
    end

    // ======================================================================
    // interrupts: sticky, write one to clear, set wins
    assign irqEvent[`DCRC_IRQ_START] = runRise;
    assign irqEvent[`DCRC_IRQ_HALT] = abortRise;
    assign irqEvent[`DCRC_IRQ_FAULT] = faultSet && !faultFlag;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStatus <= '0;
        end else begin
            if (doWrite && awIdx == `DCRC_IDX_IRQST && wStrb[0]) begin
                irqStatus <= (irqStatus & ~wData[`DCRC_IRQ_W-1:0])
                    | irqEvent;
            end else begin
                irqStatus <= irqStatus | irqEvent;
            end
        end
    end

    assign irq = |(irqStatus & irqMask);

    // ======================================================================
    // read channel, answer one cycle after the address is taken
    assign arready = !rvalid;

    always_comb begin
        rdVal = 16'h0000;
        rdHit = isMapped(araddr[`DCRC_ADDR_W-1:2]);
        case (araddr[`DCRC_ADDR_W-1:2])
            `DCRC_IDX_HIBERNATE: rdVal[0] = hibernate;
            `DCRC_IDX_RUN: rdVal[0] = runTrig;
            `DCRC_IDX_ABORT: rdVal[0] = abortTrig;
            `DCRC_IDX_ENTRY: rdVal = entry;
            `DCRC_IDX_STATE: rdVal[2:0] = coreStateCode;
            `DCRC_IDX_CLEAR: rdVal[0] = clearTrig;
            `DCRC_IDX_PMASK: rdVal[PMASK_W-1:0] = parityReportMask;
            `DCRC_IDX_FLAG: rdVal[0] = faultFlag;
            `DCRC_IDX_IRQST: rdVal[`DCRC_IRQ_W-1:0] = irqStatus;
            `DCRC_IDX_IRQMSK: rdVal[`DCRC_IRQ_W-1:0] = irqMask;
            default: rdVal = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `DCRC_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= {16'h0000, rdVal};
            rresp <= rdHit ? `DCRC_RESP_OKAY : `DCRC_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule : dcrc_core_run_control

/* File: dcrc_core_run_control_asserts.sv */
// dcrc_core_run_control_asserts.sv: port checks for the run control block
// assumes: bound to every dcrc_core_run_control instance
module dcrc_core_run_control_asserts #(
    parameter int PMASK_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic bvalid,
    input wire logic pcLoad,
    input wire logic [15:0] pcStartAddr,
    input wire logic coreHaltNow,
    input wire logic coreEnable,
    input wire logic [2:0] coreStateCode,
    input wire logic coreStallReq,
    input wire logic coreResume,
    input wire logic [PMASK_W-1:0] parityErr,
    input wire logic [PMASK_W-1:0] parityReportMask,
    input wire logic otherFault,
    input wire logic faultFlag,
    input wire logic faultMgrReset
);
    // ======================================================================
    // helpers
    logic faultIn;
    assign faultIn = (|(parityErr & ~parityReportMask)) | otherFault;
    default clocking dcrcCb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // ======================================================================
    // assertions
    a_run_launch: assert property ($rose(pcLoad) |-> $rose(bvalid) && coreStateCode == 3'h1)
        else $error("launch not tied to a run write");
    a_entry_held: assert property (pcLoad |=> $stable(pcStartAddr))
        else $error("start address moved after launch");
    a_halt_stops: assert property (coreHaltNow |-> coreStateCode == 3'h0 && !coreEnable)
        else $error("halt left core running");
    a_halt_write: assert property ($rose(coreHaltNow) |-> $rose(bvalid))
        else $error("halt without abort write");
    a_enable_code: assert property (coreEnable == (coreStateCode != 3'h0))
        else $error("enable disagrees with state");
    a_stall_enter: assert property (coreStateCode == 3'h1 && coreStallReq |=>
        coreStateCode == 3'h4 || $rose(bvalid)) else $error("stall not shown");
    a_stall_leave: assert property (coreStateCode == 3'h4 && !coreStallReq |=>
        coreStateCode == 3'h1 || $rose(bvalid)) else $error("stall did not resume");
    a_pause_hold: assert property (coreStateCode == 3'h2 && !coreResume |=>
        coreStateCode == 3'h2 || $rose(bvalid)) else $error("pause left early");
    a_fault_set: assert property (faultIn |=> faultFlag)
        else $error("fault not recorded");
    a_clear_write: assert property ($rose(faultMgrReset) |-> $rose(bvalid))
        else $error("fault reset without write");
    a_clear_flag: assert property (faultMgrReset && !$past(faultIn) |-> !faultFlag)
        else $error("flag survived clear");
    c_stall: cover property (coreStateCode == 3'h4);
    c_sleep: cover property (coreStateCode == 3'h3);
    c_halt: cover property ($rose(coreHaltNow));
    c_clear: cover property (faultMgrReset);
endmodule : dcrc_core_run_control_asserts

bind dcrc_core_run_control dcrc_core_run_control_asserts #(.PMASK_W(PMASK_W)) u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .bvalid(bvalid), .pcLoad(pcLoad),
    .pcStartAddr(pcStartAddr), .coreHaltNow(coreHaltNow), .coreEnable(coreEnable),
    .coreStateCode(coreStateCode), .coreStallReq(coreStallReq), .coreResume(coreResume),
    .parityErr(parityErr), .parityReportMask(parityReportMask), .otherFault(otherFault),
    .faultFlag(faultFlag), .faultMgrReset(faultMgrReset));

/* File: dcrc_core_run_control_tb_top.sv */
// dcrc_core_run_control_tb_top.sv: self-checking bench for the run control block
// assumes: design and checker compiled first, dcrc_cfg.svh on the include path
`include "dcrc_cfg.svh"
module dcrc_core_run_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] OK = `DCRC_RESP_OKAY;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [`DCRC_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, seed = 32'h0000_a2d6, m, e;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic coreStallReq = 1'b0, corePauseInstr = 1'b0, coreResume = 1'b0;
    logic coreSleepInstr = 1'b0, frameStart = 1'b0, blockDone = 1'b0, otherFault = 1'b0;
    logic [11:0] parityErr = 12'h000, parityReportMask;
    logic awready, wready, bvalid, arready, rvalid, coreEnable, pcLoad, coreHaltNow;
    logic coreIrqMask, faultMgrReset, faultFlag, irq;
    logic [1:0] bresp, rresp;
    logic [15:0] pcStartAddr, entry;
    logic [2:0] coreStateCode;
    logic [15:0] ridx [10] = '{`DCRC_IDX_HIBERNATE, `DCRC_IDX_RUN, `DCRC_IDX_ABORT,
        `DCRC_IDX_ENTRY, `DCRC_IDX_STATE, `DCRC_IDX_CLEAR, `DCRC_IDX_PMASK,
        `DCRC_IDX_FLAG, `DCRC_IDX_IRQST, `DCRC_IDX_IRQMSK};
    int failCount = 0;
    int totalChecks = 0;
    int nLoad = 0, nHalt = 0, nClr = 0;

    dcrc_core_run_control #(.PMASK_W(12)) u_dut (.*, .awprot(3'h0), .arprot(3'h0));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    // one-cycle strobes to the core and fault manager, counted while they stand
    always @(negedge core_clk) begin
        nLoad <= nLoad + int'(pcLoad === 1'b1);
        nHalt <= nHalt + int'(coreHaltNow === 1'b1);
        nClr <= nClr + int'(faultMgrReset === 1'b1);
    end
    // ======================================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [2:0] stcode(input int k);
        case (k)
            1: return 3'h4;
            2: return 3'h2;
            3, 4: return 3'h3;
            default: return 3'h1;
        endcase
    endfunction : stcode

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        totalChecks++;
        if (seen !== ex) begin
            failCount++;
            $display("BAD %s expected %h seen %h", nm, ex, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic pa;
        logic pw;
        logic ta;
        logic tw;
        pa = 1'b1;
        pw = 1'b1;
        awaddr <= {idx, 2'b00};
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge core_clk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge core_clk);
            if (ta) begin
                awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        repeat (rnd() % 3) @(posedge core_clk);
        bready <= 1'b1;
        do @(negedge core_clk); while (bvalid !== 1'b1);
        chk("bresp", 32'(bresp), 32'(er));
        @(posedge core_clk);
        bready <= 1'b0;
    endtask : wr

    task automatic rchk(input string nm, input logic [15:0] idx, input logic [31:0] ex,
            input logic [1:0] er);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        do @(negedge core_clk); while (arready !== 1'b1);
        @(posedge core_clk);
        arvalid <= 1'b0;
        repeat (rnd() % 3) @(posedge core_clk);
        rready <= 1'b1;
        do @(negedge core_clk); while (rvalid !== 1'b1);
        chk(nm, rdata, ex);
        chk("rresp", 32'(rresp), 32'(er));
        @(posedge core_clk);
        rready <= 1'b0;
    endtask : rchk

    task automatic ccode(input logic [2:0] ex);
        @(negedge core_clk);
        chk("code", 32'(coreStateCode), 32'(ex));
        chk("enable", 32'(coreEnable), 32'(ex != 3'h0));
        @(posedge core_clk);
    endtask : ccode

    // drives the core event that moves a running core to the state of case k
    task automatic enter(input int k);
        coreStallReq <= (k == 1);
        corePauseInstr <= (k == 2);
        coreSleepInstr <= (k == 3);
        blockDone <= (k == 4);
        @(posedge core_clk);
        {corePauseInstr, coreSleepInstr, blockDone} <= 3'h0;
    endtask : enter

    task automatic leave(input int k);
        coreStallReq <= 1'b0;
        coreResume <= (k == 2);
        frameStart <= (k >= 3);
        @(posedge core_clk);
        {coreResume, frameStart} <= 2'h0;
    endtask : leave

    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", totalChecks, failCount);
        if (failCount == 0 && totalChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : giveVerdict
    // ======================================================================
    // scenarios
    initial begin
        repeat (30000) @(posedge core_clk);
        failCount++;
        giveVerdict();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        ccode(3'h0);
        for (int i = 0; i < 10; i++) begin
            rchk("reset", ridx[i], (i == 6) ? 32'h0000_0003 : 32'h0000_0000, OK);
        end
        wr(16'hf410, 32'h0000_0001, `DCRC_RESP_SLVERR);
        rchk("unmapped", 16'hf410, 32'h0000_0000, `DCRC_RESP_SLVERR);
        wr(`DCRC_IDX_STATE, 32'h0000_0004, OK);
        rchk("state", `DCRC_IDX_STATE, 32'h0000_0000, OK);
        wr(`DCRC_IDX_ABORT, 32'hffff_fffe, OK);
        rchk("abort", `DCRC_IDX_ABORT, 32'h0000_0000, OK);
        for (int k = 0; k < 4; k++) begin
            entry = 16'(rnd());
            wr(`DCRC_IDX_ENTRY, {16'h0000, entry}, OK);
            rchk("entry", `DCRC_IDX_ENTRY, {16'h0000, entry}, OK);
            wr(`DCRC_IDX_RUN, 32'h0000_0001, OK);
            chk("pc start", 32'(pcStartAddr), {16'h0000, entry});
            ccode(3'h1);
            wr(`DCRC_IDX_ABORT, 32'h0000_0000, OK);
            wr(`DCRC_IDX_RUN, 32'h0000_0000, OK);
            ccode(3'h1);
            if (k > 0) begin
                enter(k);
                ccode(stcode(k));
                leave(k);
                ccode(3'h1);
                enter(k);
            end
            wr(`DCRC_IDX_ABORT, 32'h0000_0001, OK);
            ccode(3'h0);
            rchk("state", `DCRC_IDX_STATE, 32'h0000_0000, OK);
            coreStallReq <= 1'b0;
        end
        wr(`DCRC_IDX_HIBERNATE, 32'h0000_0001, OK);
        chk("irq mask", 32'(coreIrqMask), 32'h0000_0001);
        wr(`DCRC_IDX_RUN, 32'h0000_0001, OK);
        enter(4);
        ccode(stcode(4));
        wr(`DCRC_IDX_HIBERNATE, 32'h0000_0000, OK);
        chk("irq unmask", 32'(coreIrqMask), 32'h0000_0000);
        leave(4);
        ccode(3'h1);
        for (int i = 0; i < 8; i++) begin
            m = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_ffff : rnd();
            e = rnd();
            wr(`DCRC_IDX_PMASK, m, OK);
            rchk("pmask", `DCRC_IDX_PMASK, {20'h0_0000, m[11:0]}, OK);
            chk("mask out", 32'(parityReportMask), {20'h0_0000, m[11:0]});
            parityErr <= e[11:0];
            @(posedge core_clk);
            parityErr <= 12'h000;
            @(negedge core_clk);
            chk("flag", 32'(faultFlag), 32'(|(e[11:0] & ~m[11:0])));
            @(posedge core_clk);
            wr(`DCRC_IDX_CLEAR, 32'h0000_0001, OK);
            chk("flag clr", 32'(faultFlag), 32'h0000_0000);
            wr(`DCRC_IDX_CLEAR, 32'h0000_0000, OK);
        end
        otherFault <= 1'b1;
        @(posedge core_clk);
        otherFault <= 1'b0;
        @(posedge core_clk);
        chk("irq off", 32'(irq), 32'h0000_0000);
        rchk("irq st", `DCRC_IDX_IRQST, 32'h0000_0007, OK);
        wr(`DCRC_IDX_IRQMSK, 32'h0000_0004, OK);
        chk("irq on", 32'(irq), 32'h0000_0001);
        wr(`DCRC_IDX_IRQST, 32'h0000_0007, OK);
        chk("irq clr", 32'(irq), 32'h0000_0000);
        rchk("irq st", `DCRC_IDX_IRQST, 32'h0000_0000, OK);
        chk("launches", 32'(nLoad), 32'h0000_0005);
        chk("halts", 32'(nHalt), 32'h0000_0004);
        chk("mgr resets", 32'(nClr), 32'h0000_0008);
        giveVerdict();
    end
endmodule : dcrc_core_run_control_tb_top
